// *** inc/ctpg_defines.vh ***
`ifndef CTPG_DEFINES_VH
`define CTPG_DEFINES_VH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define CTPG_ADDR_CTRL 8'h10
`define CTPG_ADDR_IPG 8'h14
`define CTPG_ADDR_IRQ_STAT 8'h18
`define CTPG_ADDR_IRQ_MASK 8'h1c
`define CTPG_ADDR_SWRST 8'h20

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTPG_BURST_HI 15
`define CTPG_BURST_LO 8
`define CTPG_BIT_TRIG 7
`define CTPG_BIT_SCC 6
`define CTPG_BIT_ENA 3
`define CTPG_BIT_PAY 2
`define CTPG_BIT_LEN 1
`define CTPG_BIT_ERR 0
`define CTPG_CTRL_WMASK 16'hff4f

// ----------------------------------------------------------------
// reset values and frame constants
// ----------------------------------------------------------------
`define CTPG_IPG_RESET 8'h0b
`define CTPG_LEN_LONG 11'h5ee
`define CTPG_LEN_SHORT 11'h040
`define CTPG_PAT_A 8'h5a
`define CTPG_PAT_B 8'ha5
`define CTPG_LFSR_SEED 8'hff
`define CTPG_IRQ_PKT 0
`define CTPG_IRQ_BURST 1
`define CTPG_IRQ_W 2
`define CTPG_RESP_OKAY 2'h0
`define CTPG_RESP_SLVERR 2'h2

`endif

// *** src/ctpg_byte_source.v ***
`timescale 1ns/100ps
`include "ctpg_defines.vh"

// payload byte source: lfsr or alternating pattern
module ctpg_byte_source (
    input wire aclk,
    input wire aresetn,
    input wire restart,
    input wire advance,
    input wire pattern_sel,
    output wire [7:0] data
);
    reg [7:0] lfsr;
    reg phase;

    // advance lfsr and pattern phase per byte sent
    always @(posedge aclk) begin
        if (!aresetn || restart) begin
            lfsr <= `CTPG_LFSR_SEED;
            phase <= 1'b0;
        end else if (advance) begin
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            phase <= ~phase;
        end
    end

    assign data = pattern_sel ? (phase ? `CTPG_PAT_B : `CTPG_PAT_A)
                              : lfsr;
endmodule // ctpg_byte_source

// *** src/ctpg_generator.v ***
`timescale 1ns/100ps
`include "ctpg_defines.vh"

// Contract
// - zero burst is continuous, else N packets
// - trigger bit reads 0 busy, 1 done
// - writing 0 when done starts burst
// - writes to trigger ignored while busy
// - trigger valid only with scc, enable, burst
// - self clear set keeps enable after burst
// - self clear clear drops enable after burst
// - length bit picks 1518 or 64 bytes
// - payload bit picks random or 5a/a5
// - gap is ipg plus one bytes, reset 0xb
module ctpg_generator (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [7:0] tx_data,
    output reg tx_en,
    output reg tx_er,
    output reg irq
);
    // ------------------------------------------------------------
    // state machine codes
    // ------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_SEND = 3'b010;
    localparam [2:0] ST_GAP = 3'b100;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [7:0] burst;
    reg trig_done;
    reg scc;
    reg enable;
    reg pay_sel;
    reg len_sel;
    reg err_sel;
    reg [7:0] ipg;
    reg [`CTPG_IRQ_W-1:0] irq_stat;
    reg [`CTPG_IRQ_W-1:0] irq_mask;
    reg [2:0] state;
    reg [10:0] byte_cnt;
    reg [8:0] gap_cnt;
    reg [7:0] pkt_cnt;
    reg [7:0] aw_addr;
    reg aw_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg w_held;

    wire [7:0] src_data;
    wire [10:0] pkt_len;
    wire burst_mode;
    wire wr_go;
    wire rd_go;
    wire wr_ctrl;
    wire sw_rst;
    wire last_byte;
    wire last_gap;
    wire burst_end;
    wire trig_fire;
    wire [15:0] ctrl_word;

    // payload bytes
    ctpg_byte_source u_src (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(state == ST_IDLE),
        .advance(state == ST_SEND),
        .pattern_sel(pay_sel),
        .data(src_data)
    );

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    assign pkt_len = len_sel ? `CTPG_LEN_LONG : `CTPG_LEN_SHORT;
    assign burst_mode = (burst != 8'h00);
    assign wr_go = aw_held && w_held && !s_axi_bvalid;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign wr_ctrl = wr_go && (aw_addr == `CTPG_ADDR_CTRL);
    assign sw_rst = wr_go && (aw_addr == `CTPG_ADDR_SWRST) && w_data[0];
    assign last_byte = (state == ST_SEND) && (byte_cnt == pkt_len - 11'h001);
    assign last_gap = (state == ST_GAP) && (gap_cnt == {1'b0, ipg});
    assign burst_end = last_byte && burst_mode && (pkt_cnt == burst - 8'h01);
    // trigger honoured only when done and all qualifiers hold
    assign trig_fire = wr_ctrl && w_strb[0] && !w_data[`CTPG_BIT_TRIG]
        && trig_done && scc && enable && burst_mode;
    assign ctrl_word = {burst, trig_done, scc, 2'b00, enable, pay_sel,
                        len_sel, err_sel};

    // ------------------------------------------------------------
    // axi4-lite write channel: latch address and data separately
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CTPG_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready;
            s_axi_wready <= !w_held && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                case (aw_addr)
                    `CTPG_ADDR_CTRL, `CTPG_ADDR_IPG, `CTPG_ADDR_IRQ_STAT,
                    `CTPG_ADDR_IRQ_MASK, `CTPG_ADDR_SWRST:
                        s_axi_bresp <= `CTPG_RESP_OKAY;
                    default: s_axi_bresp <= `CTPG_RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CTPG_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (rd_go) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `CTPG_RESP_OKAY;
                case (s_axi_araddr)
                    `CTPG_ADDR_CTRL: s_axi_rdata <= {16'h0000, ctrl_word};
                    `CTPG_ADDR_IPG: s_axi_rdata <= {24'h000000, ipg};
                    `CTPG_ADDR_IRQ_STAT:
                        s_axi_rdata <= {30'h00000000, irq_stat};
                    `CTPG_ADDR_IRQ_MASK:
                        s_axi_rdata <= {30'h00000000, irq_mask};
                    `CTPG_ADDR_SWRST: s_axi_rdata <= 32'h0000_0000;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `CTPG_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // control fields kept across soft reset
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            burst <= 8'h00;
            scc <= 1'b0;
            trig_done <= 1'b0;
        end else begin
            if (wr_ctrl && w_strb[1])
                burst <= w_data[`CTPG_BURST_HI:`CTPG_BURST_LO];
            if (wr_ctrl && w_strb[0])
                scc <= w_data[`CTPG_BIT_SCC];
            // done flag: hardware set at burst end wins over trigger
            if (burst_end)
                trig_done <= 1'b1;
            else if (trig_fire)
                trig_done <= 1'b0;
            else if (wr_ctrl && w_strb[0] && w_data[`CTPG_BIT_ENA]
                     && !enable)
                trig_done <= 1'b0; // fresh enable starts busy
        end
    end

    // ------------------------------------------------------------
    // fields cleared by soft reset, ipg and interrupt mask
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn || sw_rst) begin
            enable <= 1'b0;
            pay_sel <= 1'b0;
            len_sel <= 1'b0;
            err_sel <= 1'b0;
            ipg <= `CTPG_IPG_RESET;
            irq_mask <= {`CTPG_IRQ_W{1'b0}};
        end else begin
            if (wr_ctrl && w_strb[0]) begin
                pay_sel <= w_data[`CTPG_BIT_PAY];
                len_sel <= w_data[`CTPG_BIT_LEN];
                err_sel <= w_data[`CTPG_BIT_ERR];
            end
            // enable: clears itself after burst unless scc is set
            if (burst_end && !scc)
                enable <= 1'b0;
            else if (wr_ctrl && w_strb[0])
                enable <= w_data[`CTPG_BIT_ENA];
            if (wr_go && aw_addr == `CTPG_ADDR_IPG && w_strb[0])
                ipg <= w_data[7:0];
            if (wr_go && aw_addr == `CTPG_ADDR_IRQ_MASK && w_strb[0])
                irq_mask <= w_data[`CTPG_IRQ_W-1:0];
        end
    end

    // sticky status: set beats write-one-to-clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= {`CTPG_IRQ_W{1'b0}};
            irq <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~((wr_go && w_strb[0] &&
                aw_addr == `CTPG_ADDR_IRQ_STAT) ?
                w_data[`CTPG_IRQ_W-1:0] : {`CTPG_IRQ_W{1'b0}}))
                | {burst_end, last_byte};
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // frame sequencer
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn || sw_rst) begin
            state <= ST_IDLE;
            byte_cnt <= 11'h000;
            gap_cnt <= 9'h000;
            pkt_cnt <= 8'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    byte_cnt <= 11'h000;
                    pkt_cnt <= 8'h00;
                    // start on enable when not done, or on a trigger
                    if ((enable && !trig_done) || trig_fire)
                        state <= ST_SEND;
                    else if (enable && !burst_mode)
                        state <= ST_SEND;
                end
                ST_SEND: begin
                    byte_cnt <= byte_cnt + 11'h001;
                    if (last_byte) begin
                        byte_cnt <= 11'h000;
                        gap_cnt <= 9'h000;
                        pkt_cnt <= pkt_cnt + 8'h01;
                        state <= burst_end ? ST_IDLE : ST_GAP;
                    end
                end
                ST_GAP: begin
                    gap_cnt <= gap_cnt + 9'h001;
                    if (last_gap)
                        state <= enable ? ST_SEND : ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // transmit outputs registered from sequencer state
    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_data <= 8'h00;
            tx_en <= 1'b0;
            tx_er <= 1'b0;
        end else begin
            tx_en <= (state == ST_SEND);
            tx_data <= (state == ST_SEND) ? src_data : 8'h00;
            tx_er <= (state == ST_SEND) && err_sel && last_byte;
        end
    end
endmodule // ctpg_generator

// *** tb/ctpg_tx_sink.sv ***
`timescale 1ns/100ps
// link partner: measures frames arriving on the transmit path
module ctpg_tx_sink (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] tx_data,
    input wire logic tx_en,
    output logic [15:0] frames,
    output logic [10:0] flen,
    output logic [10:0] gap,
    output logic [15:0] head
);
    logic [10:0] run;
    logic [10:0] idle;
    // count bytes per frame, idle bytes between frames, first two bytes
    always @(posedge aclk) begin
        if (!aresetn) begin
            frames <= '0;
            run <= '0;
            idle <= '0;
        end else if (tx_en) begin
            run <= run + 11'h001;
            idle <= '0;
            if (run == 11'h000)
                gap <= idle;
            if (run < 11'h002)
                head <= {head[7:0], tx_data};
        end else begin
            idle <= idle + 11'h001;
            run <= '0;
            if (run != 11'h000) begin
                frames <= frames + 16'h0001;
                flen <= run;
            end
        end
    end
endmodule // ctpg_tx_sink

// *** tb/ctpg_generator_properties.sv ***
`timescale 1ns/100ps
`include "ctpg_defines.vh"
// bus and frame checks on the generator ports
module ctpg_checker (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire tx_en,
    input wire tx_er,
    input wire irq
);
    logic [10:0] run;
    // length of the current transmit run
    always @(posedge aclk) begin
        if (!aresetn || !tx_en)
            run <= '0;
        else
            run <= run + 11'h001;
    end
    // ----------
    // assertions
    // ----------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    frame_len_a: assert property ($fell(tx_en) |->
        (run == `CTPG_LEN_SHORT || run == `CTPG_LEN_LONG))
        else $error("frame length not 64 or 1518");
    err_in_frame_a: assert property (tx_er |-> tx_en)
        else $error("error flag outside a frame");
    err_pulse_a: assert property (tx_er |=> !tx_er)
        else $error("error flag longer than one byte");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("write response dropped");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid) else $error("read response dropped");
    write_resp_a: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    read_resp_a: assert property (s_axi_arvalid && s_axi_arready
        |-> ##[1:2] s_axi_rvalid) else $error("read response late");
    err_data_a: assert property (s_axi_rvalid &&
        s_axi_rresp == `CTPG_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
    one_write_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("second write accepted");
    cover property ($fell(tx_en) && run == `CTPG_LEN_LONG);
    cover property (s_axi_rvalid && s_axi_rresp == `CTPG_RESP_SLVERR);
    cover property ($rose(irq));
endmodule // ctpg_checker

bind ctpg_generator ctpg_checker ctpg_checker_i (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .tx_en(tx_en), .tx_er(tx_er), .irq(irq));

// *** tb/test_copper_test_packet_generator.sv ***
`timescale 1ns/100ps
`include "ctpg_defines.vh"
module test_copper_test_packet_generator;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rd;
    logic [1:0] bs, rs;
    wire awready, wready, bvalid, arready, rvalid, tx_en, tx_er, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] tx_data;
    wire [15:0] frames, head;
    wire [10:0] flen, gap;
    int n_fail, checked;
    logic er_seen;
    typedef struct {logic [7:0] a; logic [31:0] w, e; logic [1:0] r;} ctpg_row;
    ctpg_row rows [4] = '{
        '{`CTPG_ADDR_IPG, 32'h3, 32'h3, `CTPG_RESP_OKAY},
        '{`CTPG_ADDR_IRQ_MASK, 32'h2, 32'h2, `CTPG_RESP_OKAY},
        '{8'h24, 32'h55, 32'h0, `CTPG_RESP_SLVERR},
        '{`CTPG_ADDR_CTRL, 32'h2c4, 32'h244, `CTPG_RESP_OKAY}};

    ctpg_generator ctpg_generator_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_data(tx_data),
        .tx_en(tx_en), .tx_er(tx_er), .irq(irq));
    ctpg_tx_sink ctpg_tx_sink_i (.aclk(aclk), .aresetn(aresetn),
        .tx_data(tx_data), .tx_en(tx_en), .frames(frames), .flen(flen),
        .gap(gap), .head(head));

    // sticky record of an errored byte on the transmit path
    always @(posedge aclk) begin
        er_seen <= aresetn && (er_seen || tx_er);
    end

    // 25 MHz clock
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // -----
    // tasks
    // -----
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic fin(string s);
        $display("test %s finished, mismatches %0d", s, n_fail);
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        int t;
        t = 0;
        @(posedge aclk); // keeps bready to one assignment per step
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            bs = bresp;
            t++;
        end while (!bvalid && t < 50);
        bready <= 1'b0;
        if (!bvalid) begin
            n_fail++;
            summarize();
        end
    endtask
    task automatic rd_reg(logic [7:0] a);
        int t;
        t = 0;
        @(posedge aclk); // keeps rready to one assignment per step
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            rd = rdata;
            rs = rresp;
            t++;
        end while (!rvalid && t < 50);
        rready <= 1'b0;
        if (!rvalid) begin
            n_fail++;
            summarize();
        end
    endtask
    task automatic wait_frames(logic [15:0] n);
        int t;
        for (t = 0; t < 20000 && frames < n; t++)
            @(posedge aclk);
        if (!(frames >= n)) begin
            n_fail++;
            summarize();
        end
    endtask
    // -------------
    // main sequence
    // -------------
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        n_fail = 0;
        checked = 0;
        tick(20);
        aresetn <= 1'b1;
        tick(2);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd_reg(rows[i].a);
            check("resp", {bs, rs}, {rows[i].r, rows[i].r});
            check("data", rd, rows[i].e);
        end
        fin("table");
        // burst of two patterned short frames, enable kept
        wr(`CTPG_ADDR_CTRL, 32'h24c);
        rd_reg(`CTPG_ADDR_CTRL);
        check("busy", rd[7], 1'b0);
        wait_frames(2);
        tick(8);
        rd_reg(`CTPG_ADDR_CTRL);
        check("done", rd, 32'h2cc);
        check("len", flen, `CTPG_LEN_SHORT);
        check("head", head, 16'h5aa5);
        check("gap", gap, 11'h004);
        check("irq", irq, 1'b1);
        wr(`CTPG_ADDR_IRQ_STAT, 32'h2);
        tick(3);
        check("irqclr", irq, 1'b0);
        tick(300);
        check("count", frames, 16'h2);
        fin("burst");
        // retrigger when done, writes while busy ignored
        wr(`CTPG_ADDR_CTRL, 32'h24c);
        tick(4);
        wr(`CTPG_ADDR_CTRL, 32'h24c);
        wr(`CTPG_ADDR_CTRL, 32'h2cc);
        wait_frames(4);
        tick(300);
        check("retrig", frames, 16'h4);
        fin("trigger");
        // one long random frame, enable drops itself
        wr(`CTPG_ADDR_CTRL, 32'h0);
        wr(`CTPG_ADDR_CTRL, 32'h10a);
        wait_frames(5);
        tick(8);
        rd_reg(`CTPG_ADDR_CTRL);
        check("selfclr", rd[3], 1'b0);
        check("long", flen, `CTPG_LEN_LONG);
        check("prbs", head == 16'h5aa5, 1'b0);
        fin("single");
        // continuous until enable cleared
        wr(`CTPG_ADDR_CTRL, 32'h8);
        wait_frames(9);
        rd_reg(`CTPG_ADDR_CTRL);
        check("cont", rd[3], 1'b1);
        check("cgap", gap, 11'h004);
        wr(`CTPG_ADDR_CTRL, 32'h0);
        tick(100);
        rd = {16'h0, frames};
        tick(200);
        check("stop", frames, rd);
        fin("continuous");
        // soft reset in mid-burst with errored frames
        check("noer", er_seen, 1'b0);
        wr(`CTPG_ADDR_IPG, 32'hff); // long gap: reset lands between frames
        wr(`CTPG_ADDR_CTRL, 32'h34d);
        tick(80);
        wr(`CTPG_ADDR_SWRST, 32'h1);
        check("txer", er_seen, 1'b1);
        rd_reg(`CTPG_ADDR_CTRL);
        check("swrst", rd, 32'h340);
        rd_reg(`CTPG_ADDR_IPG);
        check("swipg", rd, 32'hb);
        fin("soft reset");
        // hardware reset clears control register, ipg returns to 0xb
        aresetn <= 1'b0;
        tick(20);
        aresetn <= 1'b1;
        tick(2);
        rd_reg(`CTPG_ADDR_CTRL);
        check("hwrst", rd, 32'h0);
        rd_reg(`CTPG_ADDR_IPG);
        check("hwipg", rd, 32'hb);
        fin("hard reset");
        summarize();
    end
endmodule // test_copper_test_packet_generator
